//--- core/sps_clkdiv.sv
// Divider producing one-cycle enable pulses for the master serial clock
module sps_clkdiv #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] div,
    output logic                  tick
);
    logic [WIDTH-1:0] cnt_q;

    // ==========================================================
    // Half-period tick every div+1 cycles
    always_ff @(posedge ref_clk) begin
        if (reset || !run) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q >= div) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + WIDTH'(1);
            tick  <= 1'b0;
        end
    end
endmodule

//--- core/sps_core.sv
// Serial port core: APB registers, master and slave shifters, select-line modes
// Notes on behaviour
// - Master drives master-out; slave only reads it.
// - Master samples master-in; slave drives it.
// - Bytes travel most significant bit first on both lines.
// - Master shows shift register top bit on master-out in both forms.
// - Master-in floats when disabled or as unselected 4-wire slave.
// - A 3-wire slave always drives its top bit on master-in.
// - Master makes the serial clock; slave takes it from outside.
// - Unselected 4-wire slave ignores all serial clock edges.
// - Select mode 00 is 3-wire; slave then counts as always selected.
// - Mode 01 slave: low select line selects the port.
// - Mode 01 master: falling select line turns master function off.
// - Upper mode bit set: select line output equals lower mode bit.
// - No select pin requested in 3-wire forms; requested otherwise.
// - Full duplex as master or slave; shared multi-master bus.
// - Mode fault clears master and enable bits and sets fault flag.
// - 4-wire slave resets its bit counter on falling select line.
// - Slave counts eight edges, then sets done and stores the byte if the receive buffer is empty.
//
// Design decisions made here: the register offsets and the APB slave port.
module sps_core (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                mosi_i,
    input  wire logic                miso_i,
    input  wire logic                sck_i,
    input  wire logic                ss_n_i,
    output sps_pkg::sps_pins_s       pins
);
    // ==========================================================
    // Registers
    logic                 enable_q;
    logic                 master_q;
    logic [1:0]           mode_q;
    logic [7:0]           clkdiv_q;
    logic                 done_q;
    logic                 fault_q;
    logic                 ovrn_q;
    logic                 wcol_q;
    logic [7:0]           txbuf_q;
    logic                 txfull_q;
    logic [7:0]           shift_q;
    logic                 shfull_q;
    logic [7:0]           rxbuf_q;
    logic                 rxfull_q;
    logic [3:0]           bitcnt_q;
    logic                 sck_q;
    logic                 miso_samp_q;
    sps_pkg::sps_mstate_e mst_q;

    logic sck_rise, sck_fall;
    logic ss_lvl, ss_rise, ss_fall;
    logic tick;
    logic mosi_s1_q, mosi_s_q;
    logic miso_s1_q, miso_s_q;

    logic wr, rd, wr_ctrl, wr_stat, wr_data, rd_data;
    logic is_slave, three_wire, selected, fault_evt;
    logic m_byte_done, s_byte_done, s_sample, s_shift, load_sh;

    // ==========================================================
    // Pin synchronisers
    // Serial clock idles low in mode 0
    sps_sync #(
        .IDLE_LEVEL (1'b0)
    ) u_sck_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (sck_i),
        .level_q  (),
        .rise     (sck_rise),
        .fall     (sck_fall)
    );

    sps_sync u_ss_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (ss_n_i),
        .level_q  (ss_lvl),
        .rise     (ss_rise),
        .fall     (ss_fall)
    );

    // Data pins sampled twice as well; only the second stage is read
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mosi_s1_q <= 1'b0;
            mosi_s_q  <= 1'b0;
            miso_s1_q <= 1'b0;
            miso_s_q  <= 1'b0;
        end else begin
            mosi_s1_q <= mosi_i;
            mosi_s_q  <= mosi_s1_q;
            miso_s1_q <= miso_i;
            miso_s_q  <= miso_s1_q;
        end
    end

    sps_clkdiv #(
        .WIDTH (8)
    ) u_div (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (mst_q == sps_pkg::SPS_M_LEAD || mst_q == sps_pkg::SPS_M_TRAIL),
        .div     (clkdiv_q),
        .tick    (tick)
    );

    // ==========================================================
    // Decode; zero wait states
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & penable & ~pwrite;
    assign wr_ctrl = wr && paddr == sps_pkg::CTRL_OFFSET;
    assign wr_stat = wr && paddr == sps_pkg::STATUS_OFFSET;
    assign wr_data = wr && paddr == sps_pkg::DATA_OFFSET;
    assign rd_data = rd && paddr == sps_pkg::DATA_OFFSET;

    assign is_slave   = enable_q & ~master_q;
    assign three_wire = mode_q == sps_pkg::SPS_SEL_3WIRE;
    assign selected   = three_wire | (mode_q == sps_pkg::SPS_SEL_INPUT & ~ss_lvl);
    // Fault only in multi-master mode on a falling select line
    assign fault_evt  = enable_q & master_q & (mode_q == sps_pkg::SPS_SEL_INPUT) & ss_fall;

    // Slave edges: sample on rise, shift on fall (phase 0, idle low)
    assign s_sample    = is_slave & selected & sck_rise;
    assign s_shift     = is_slave & selected & sck_fall;
    assign s_byte_done = s_sample && bitcnt_q == 4'(sps_pkg::BYTE_BITS - 1);
    assign m_byte_done = mst_q == sps_pkg::SPS_M_DONE;

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                sps_pkg::CTRL_OFFSET:   prdata = {28'h0, mode_q, master_q, enable_q};
                sps_pkg::STATUS_OFFSET: prdata = {26'h0, ~ss_lvl, mst_q != sps_pkg::SPS_M_IDLE,
                                                  wcol_q, ovrn_q, fault_q, done_q};
                sps_pkg::DATA_OFFSET:   prdata = {24'h0, rxbuf_q};
                sps_pkg::CLKDIV_OFFSET: prdata = {24'h0, clkdiv_q};
                default:                prdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Control register; fault beats a same-cycle write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enable_q <= 1'b0;
            master_q <= 1'b0;
            mode_q   <= sps_pkg::MODE_RESET;
            clkdiv_q <= sps_pkg::CLKDIV_RESET;
        end else begin
            if (wr_ctrl) begin
                enable_q <= pwdata[sps_pkg::CTRL_ENABLE_BIT];
                master_q <= pwdata[sps_pkg::CTRL_MASTER_BIT];
                mode_q   <= pwdata[sps_pkg::CTRL_MODE_HI:sps_pkg::CTRL_MODE_LO];
            end
            if (wr && paddr == sps_pkg::CLKDIV_OFFSET) begin
                clkdiv_q <= pwdata[7:0];
            end
            if (fault_evt) begin
                enable_q <= 1'b0;
                master_q <= 1'b0;
            end
        end
    end

    // Sticky flags: write one to clear, set wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_q  <= 1'b0;
            fault_q <= 1'b0;
            ovrn_q  <= 1'b0;
            wcol_q  <= 1'b0;
        end else begin
            done_q  <= (done_q & ~(wr_stat & pwdata[sps_pkg::STAT_DONE_BIT]))
                       | m_byte_done | s_byte_done;
            fault_q <= (fault_q & ~(wr_stat & pwdata[sps_pkg::STAT_FAULT_BIT]))
                       | fault_evt;
            ovrn_q  <= (ovrn_q & ~(wr_stat & pwdata[sps_pkg::STAT_OVRN_BIT]))
                       | (s_byte_done & rxfull_q);
            wcol_q  <= (wcol_q & ~(wr_stat & pwdata[sps_pkg::STAT_WCOL_BIT]))
                       | (wr_data & txfull_q);
        end
    end

    // ==========================================================
    // Transmit buffer and shift register load
    // Buffer empties only when the shift register really takes the byte,
    // otherwise a slave with a stale bit count would drop it
    assign load_sh = txfull_q & ~shfull_q & (master_q ? (mst_q == sps_pkg::SPS_M_IDLE)
                                                      : (bitcnt_q == 4'h0 && !s_shift));

    always_ff @(posedge ref_clk) begin
        if (reset || !enable_q) begin
            txfull_q <= 1'b0;
            txbuf_q  <= 8'h00;
        end else if (wr_data && !txfull_q) begin
            txfull_q <= 1'b1;
            txbuf_q  <= pwdata[7:0];
        end else if (load_sh) begin
            txfull_q <= 1'b0;
        end
    end

    // Master sequencer
    always_ff @(posedge ref_clk) begin
        if (reset || !enable_q || !master_q) begin
            mst_q <= sps_pkg::SPS_M_IDLE;
            sck_q <= 1'b0;
        end else begin
            case (mst_q)
                sps_pkg::SPS_M_IDLE: begin
                    if (shfull_q) begin
                        mst_q <= sps_pkg::SPS_M_LEAD;
                    end
                end
                sps_pkg::SPS_M_LEAD: begin
                    if (tick) begin
                        sck_q <= 1'b1;
                        mst_q <= sps_pkg::SPS_M_TRAIL;
                    end
                end
                sps_pkg::SPS_M_TRAIL: begin
                    if (tick) begin
                        sck_q <= 1'b0;
                        mst_q <= (bitcnt_q == 4'(sps_pkg::BYTE_BITS)) ? sps_pkg::SPS_M_DONE
                                                                      : sps_pkg::SPS_M_LEAD;
                    end
                end
                sps_pkg::SPS_M_DONE: mst_q <= sps_pkg::SPS_M_IDLE;
                default:             mst_q <= sps_pkg::SPS_M_IDLE;
            endcase
        end
    end

    // Shift register, bit counter and receive buffer
    always_ff @(posedge ref_clk) begin
        if (reset || !enable_q) begin
            shift_q     <= 8'h00;
            shfull_q    <= 1'b0;
            bitcnt_q    <= 4'h0;
            miso_samp_q <= 1'b0;
        end else if (master_q) begin
            if (load_sh && mst_q == sps_pkg::SPS_M_IDLE) begin
                shift_q  <= txbuf_q;
                shfull_q <= 1'b1;
                bitcnt_q <= 4'h0;
            end else if (mst_q == sps_pkg::SPS_M_LEAD && tick) begin
                miso_samp_q <= miso_s_q;
                bitcnt_q    <= bitcnt_q + 4'h1;
            end else if (mst_q == sps_pkg::SPS_M_TRAIL && tick) begin
                shift_q <= {shift_q[6:0], miso_samp_q};
            end else if (m_byte_done) begin
                shfull_q <= 1'b0;
            end
        end else begin
            if (mode_q == sps_pkg::SPS_SEL_INPUT && ss_fall) begin
                bitcnt_q <= 4'h0;
            end else if (s_byte_done) begin
                bitcnt_q <= 4'h0;
                shfull_q <= 1'b0;
            end else if (s_sample) begin
                bitcnt_q <= bitcnt_q + 4'h1;
            end
            if (s_sample) begin
                miso_samp_q <= mosi_s_q;
            end
            if (s_shift) begin
                shift_q <= {shift_q[6:0], miso_samp_q};
            end else if (load_sh && bitcnt_q == 4'h0) begin
                shift_q  <= txbuf_q;
                shfull_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rxbuf_q  <= 8'h00;
            rxfull_q <= 1'b0;
        end else begin
            if (m_byte_done && !rxfull_q) begin
                rxbuf_q  <= shift_q;
                rxfull_q <= 1'b1;
            end else if (s_byte_done && !rxfull_q) begin
                rxbuf_q  <= {shift_q[6:0], mosi_s_q};
                rxfull_q <= 1'b1;
            end else if (rd_data) begin
                rxfull_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Pin drive; enables are active low
    always_comb begin
        pins.mosi_o     = shift_q[7];
        pins.mosi_oe_n  = ~(enable_q & master_q);
        pins.sck_o      = sck_q;
        pins.sck_oe_n   = ~(enable_q & master_q);
        pins.miso_o     = shift_q[7];
        pins.miso_oe_n  = ~(is_slave & selected);
        pins.ss_n_o     = mode_q[0];
        pins.ss_n_oe_n  = ~mode_q[1];
        pins.ss_pin_req = ~three_wire;
    end

    // ==========================================================
    // Checks
    chk_miso_float: assert property (@(posedge ref_clk) disable iff (reset)
        (!enable_q || (!master_q && mode_q == sps_pkg::SPS_SEL_INPUT && ss_lvl))
        |-> pins.miso_oe_n)
        else $error("miso driven while disabled or unselected");
    chk_three_wire: assert property (@(posedge ref_clk) disable iff (reset)
        (is_slave && three_wire) |-> (!pins.miso_oe_n && pins.miso_o == shift_q[7]))
        else $error("3-wire slave not driving top bit");
    chk_mosi_master: assert property (@(posedge ref_clk) disable iff (reset)
        (enable_q && master_q) |-> (!pins.mosi_oe_n && pins.mosi_o == shift_q[7]))
        else $error("master not driving mosi");
    chk_fault_clear: assert property (@(posedge ref_clk) disable iff (reset)
        fault_evt |=> (!enable_q && !master_q && fault_q))
        else $error("mode fault did not disable port");
    chk_ss_output: assert property (@(posedge ref_clk) disable iff (reset)
        mode_q[1] |-> (!pins.ss_n_oe_n && pins.ss_n_o == mode_q[0]))
        else $error("select output level wrong");
    chk_pin_request: assert property (@(posedge ref_clk) disable iff (reset)
        pins.ss_pin_req == (mode_q != sps_pkg::SPS_SEL_3WIRE))
        else $error("select pin request wrong");
    chk_ignore_sck: assert property (@(posedge ref_clk) disable iff (reset)
        (is_slave && mode_q == sps_pkg::SPS_SEL_INPUT && ss_lvl && !ss_fall && !wr_ctrl)
        |=> $stable(bitcnt_q))
        else $error("unselected slave counted a clock edge");
    chk_bit_reset: assert property (@(posedge ref_clk) disable iff (reset)
        (is_slave && mode_q == sps_pkg::SPS_SEL_INPUT && ss_fall && !wr_ctrl)
        |=> bitcnt_q == 4'h0)
        else $error("bit counter not reset on select fall");
    chk_slave_done: assert property (@(posedge ref_clk) disable iff (reset)
        s_byte_done |=> done_q)
        else $error("done flag not set after eighth bit");
    chk_sck_slave: assert property (@(posedge ref_clk) disable iff (reset)
        !master_q |-> pins.sck_oe_n)
        else $error("slave drives serial clock");
    chk_tx_load: assert property (@(posedge ref_clk) disable iff (reset)
        (enable_q && $fell(txfull_q)) |-> shfull_q)
        else $error("tx byte dropped before reaching shift register");
endmodule

//--- core/sps_pkg.sv
// Package: register map, field layout and timing constants for the serial port
package sps_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] DATA_OFFSET   = 8'h08;
    localparam logic [7:0] CLKDIV_OFFSET = 8'h0C;

    // ==========================================================
    // Control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_MODE_LO    = 2;
    localparam int CTRL_MODE_HI    = 3;

    // Status field positions
    localparam int STAT_DONE_BIT   = 0;
    localparam int STAT_FAULT_BIT  = 1;
    localparam int STAT_OVRN_BIT   = 2;
    localparam int STAT_WCOL_BIT   = 3;
    localparam int STAT_BUSY_BIT   = 4;
    localparam int STAT_SEL_BIT    = 5;

    // ==========================================================
    // Reset values and bits per byte
    localparam logic [1:0] MODE_RESET   = 2'h1;
    localparam logic [7:0] CLKDIV_RESET = 8'h03;
    localparam int         BYTE_BITS    = 8;

    // Select-line modes
    typedef enum logic [1:0] {
        SPS_SEL_3WIRE = 2'h0,
        SPS_SEL_INPUT = 2'h1,
        SPS_SEL_OUT0  = 2'h2,
        SPS_SEL_OUT1  = 2'h3
    } sps_sel_mode_e;

    // Master shifter states, Gray along the path
    typedef enum logic [1:0] {
        SPS_M_IDLE  = 2'b00,
        SPS_M_LEAD  = 2'b01,
        SPS_M_TRAIL = 2'b11,
        SPS_M_DONE  = 2'b10
    } sps_mstate_e;

    // Pin bundle toward the pads
    typedef struct packed {
        logic mosi_o;
        logic mosi_oe_n;
        logic miso_o;
        logic miso_oe_n;
        logic sck_o;
        logic sck_oe_n;
        logic ss_n_o;
        logic ss_n_oe_n;
        logic ss_pin_req;
    } sps_pins_s;

endpackage

//--- core/sps_sync.sv
// Two-stage synchroniser with edge outputs for one external pin
module sps_sync #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      level_q,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;

    // ==========================================================
    // Only sync_q reads meta_q
    // Reset to the pin's idle level, else a false edge follows reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_q  <= IDLE_LEVEL;
            sync_q  <= IDLE_LEVEL;
            level_q <= IDLE_LEVEL;
        end else begin
            meta_q  <= async_in;
            sync_q  <= meta_q;
            level_q <= sync_q;
        end
    end

    assign rise = sync_q & ~level_q;
    assign fall = ~sync_q & level_q;
endmodule

//--- testbench/sps_far_end.sv
// Far-side model: a serial master or slave facing the port
module sps_far_end (
    input  wire logic ref_clk,
    input  wire logic mosi_line,
    input  wire logic miso_line,
    input  wire logic sck_line,
    output logic      p_mosi,
    output logic      p_miso,
    output logic      p_sck,
    output logic      p_ss_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       junk_q;
    logic       m_act;
    logic       m_bit;
    logic       s_on;
    logic [7:0] s_sh;
    logic [7:0] s_rx;

    initial begin
        junk_q = 1'b0;
        m_act  = 1'b0;
        m_bit  = 1'b0;
        s_on   = 1'b0;
        s_sh   = 8'h00;
        s_rx   = 8'h00;
        p_sck  = 1'b0;
        p_ss_n = 1'b1;
    end

    // Released lines toggle so a stale bit can never pass for data
    always @(posedge ref_clk) begin
        junk_q <= ~junk_q;
    end
    assign p_mosi = m_act ? m_bit : junk_q;
    assign p_miso = s_on ? s_sh[7] : junk_q;

    // =========================================
    // Slave role: only slave on the bus, msb first
    always @(posedge sck_line) begin
        if (s_on) begin
            s_rx <= {s_rx[6:0], mosi_line};
        end
    end
    always @(negedge sck_line) begin
        if (s_on) begin
            s_sh <= {s_sh[6:0], 1'b0};
        end
    end

    task automatic slave_arm(input logic [7:0] b);
        s_sh = b;
        s_rx = 8'h00;
        s_on = 1'b1;
    endtask

    task automatic set_ss(input logic v);
        #2;
        p_ss_n = v;
    endtask

    // =========================================
    // Master role: 64 ns clock, low between frames
    // Edges land off the system clock edge to avoid sampling races
    task automatic shift_out(input logic [7:0] tx, input int nbits, input logic sel,
                             output logic [7:0] rx);
        rx = 8'h00;
        #2;
        p_ss_n = ~sel;
        #40;
        m_act = 1'b1;
        for (int i = 7; i > 7 - nbits; i--) begin
            m_bit = tx[i];
            #32;
            p_sck = 1'b1;
            rx = {rx[6:0], miso_line};
            #32;
            p_sck = 1'b0;
        end
        #32;
        m_act = 1'b0;
        p_ss_n = 1'b1;
        // Select stays high long enough for the next frame's falling edge
        #64;
    endtask
endmodule

//--- testbench/tb_top.sv
// Top-level bench: APB access, pin checks and serial transfers
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk;
    logic               reset;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    sps_pkg::sps_pins_s pins;
    logic               p_mosi;
    logic               p_miso;
    logic               p_sck;
    logic               p_ss_n;
    wire                mosi_w;
    wire                miso_w;
    wire                sck_w;
    wire                ss_w;
    int                 fails = 0;
    int                 n_checks = 0;
    int                 cycles = 0;

    // Each line carries whichever party enables its driver
    assign mosi_w = (pins.mosi_oe_n === 1'b0) ? pins.mosi_o : p_mosi;
    assign miso_w = (pins.miso_oe_n === 1'b0) ? pins.miso_o : p_miso;
    assign sck_w  = (pins.sck_oe_n === 1'b0) ? pins.sck_o : p_sck;
    assign ss_w   = (pins.ss_n_oe_n === 1'b0) ? pins.ss_n_o : p_ss_n;

    sps_core sps_core_i (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mosi_i(mosi_w), .miso_i(miso_w), .sck_i(sck_w), .ss_n_i(ss_w),
        .pins(pins));
    sps_far_end sps_far_end_i (.ref_clk(ref_clk), .mosi_line(mosi_w), .miso_line(miso_w),
        .sck_line(sck_w), .p_mosi(p_mosi), .p_miso(p_miso), .p_sck(p_sck), .p_ss_n(p_ss_n));

    always #4 ref_clk = ~ref_clk;

    // =========================================
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(a, 1'b0, 32'h0, r);
        check(what, exp, r);
    endtask

    task automatic wait_done();
        logic [31:0] r;
        r = 32'h0;
        // Ends when the done flag reads one; the hang guard ends a stuck wait
        while (r[sps_pkg::STAT_DONE_BIT] !== 1'b1) begin
            apb(sps_pkg::STATUS_OFFSET, 1'b0, 32'h0, r);
        end
    endtask

    function automatic logic [31:0] cw(input logic [1:0] m, input logic ms, input logic en);
        cw = 32'h0;
        cw[sps_pkg::CTRL_MODE_HI:sps_pkg::CTRL_MODE_LO] = m;
        cw[sps_pkg::CTRL_MASTER_BIT] = ms;
        cw[sps_pkg::CTRL_ENABLE_BIT] = en;
    endfunction

    // Hang guard, well above the several hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            give_verdict();
        end
    end

    // =========================================
    // Tests
    initial begin
        logic [7:0] rx;
        ref_clk = 1'b0;
        reset   = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        rd_chk("ctrl reset", sps_pkg::CTRL_OFFSET, cw(sps_pkg::MODE_RESET, 1'b0, 1'b0));
        rd_chk("clkdiv reset", sps_pkg::CLKDIV_OFFSET, {24'h0, sps_pkg::CLKDIV_RESET});
        rd_chk("unmapped read", 8'h10, 32'h0);
        check("select pin request", 32'h1, {31'h0, pins.ss_pin_req});
        check("miso off disabled", 32'h1, {31'h0, pins.miso_oe_n});
        $display("test reset ends");
        for (int m = 0; m < 4; m++) begin
            wr(sps_pkg::CTRL_OFFSET, cw(m[1:0], 1'b1, 1'b1));
            repeat (3) @(posedge ref_clk);
            check("select pin request", {31'h0, m != 0}, {31'h0, pins.ss_pin_req});
            check("select drive", {31'h0, ~m[1]}, {31'h0, pins.ss_n_oe_n});
            check("select level", {31'h0, m[0]}, {31'h0, pins.ss_n_o});
            check("mosi drive master", 32'h0, {31'h0, pins.mosi_oe_n});
            check("sck drive master", 32'h0, {31'h0, pins.sck_oe_n});
            check("miso off master", 32'h1, {31'h0, pins.miso_oe_n});
        end
        $display("test select modes ends");
        wr(sps_pkg::CTRL_OFFSET, cw(2'h0, 1'b1, 1'b1));
        sps_far_end_i.slave_arm(8'hA5);
        wr(sps_pkg::DATA_OFFSET, 32'h3C);
        wait_done();
        check("far end received", 32'h3C, {24'h0, sps_far_end_i.s_rx});
        rd_chk("master rx byte", sps_pkg::DATA_OFFSET, 32'hA5);
        sps_far_end_i.s_on = 1'b0;
        wr(sps_pkg::STATUS_OFFSET, 32'h1);
        rd_chk("done cleared", sps_pkg::STATUS_OFFSET, 32'h0);
        $display("test master transfer ends");
        wr(sps_pkg::CTRL_OFFSET, cw(2'h1, 1'b0, 1'b1));
        repeat (4) @(posedge ref_clk);
        check("miso off unselected", 32'h1, {31'h0, pins.miso_oe_n});
        sps_far_end_i.shift_out(8'hFF, 8, 1'b0, rx);
        rd_chk("edges while unselected", sps_pkg::STATUS_OFFSET, 32'h0);
        wr(sps_pkg::DATA_OFFSET, 32'h96);
        sps_far_end_i.shift_out(8'h5A, 8, 1'b1, rx);
        check("slave sent byte", 32'h96, {24'h0, rx});
        wait_done();
        rd_chk("slave done flag", sps_pkg::STATUS_OFFSET, 32'h1);
        rd_chk("slave rx byte", sps_pkg::DATA_OFFSET, 32'h5A);
        wr(sps_pkg::STATUS_OFFSET, 32'h1);
        sps_far_end_i.shift_out(8'hF0, 3, 1'b1, rx);
        sps_far_end_i.shift_out(8'hC3, 8, 1'b1, rx);
        wait_done();
        rd_chk("byte after aborted", sps_pkg::DATA_OFFSET, 32'hC3);
        wr(sps_pkg::STATUS_OFFSET, 32'h1);
        $display("test four-wire slave ends");
        wr(sps_pkg::CTRL_OFFSET, cw(2'h0, 1'b0, 1'b1));
        repeat (4) @(posedge ref_clk);
        check("miso drive three-wire", 32'h0, {31'h0, pins.miso_oe_n});
        wr(sps_pkg::DATA_OFFSET, 32'h81);
        sps_far_end_i.shift_out(8'h7E, 8, 1'b0, rx);
        check("three-wire sent byte", 32'h81, {24'h0, rx});
        wait_done();
        rd_chk("three-wire rx byte", sps_pkg::DATA_OFFSET, 32'h7E);
        wr(sps_pkg::CTRL_OFFSET, cw(2'h0, 1'b0, 1'b0));
        repeat (3) @(posedge ref_clk);
        check("miso off disabled", 32'h1, {31'h0, pins.miso_oe_n});
        $display("test three-wire slave ends");
        wr(sps_pkg::STATUS_OFFSET, 32'hF);
        wr(sps_pkg::CTRL_OFFSET, cw(2'h1, 1'b1, 1'b1));
        sps_far_end_i.set_ss(1'b0);
        repeat (8) @(posedge ref_clk);
        rd_chk("ctrl after fault", sps_pkg::CTRL_OFFSET, cw(2'h1, 1'b0, 1'b0));
        check("mosi off after fault", 32'h1, {31'h0, pins.mosi_oe_n});
        sps_far_end_i.set_ss(1'b1);
        repeat (8) @(posedge ref_clk);
        rd_chk("fault flag", sps_pkg::STATUS_OFFSET, 32'h2);
        $display("test mode fault ends");
        give_verdict();
    end
endmodule
